// file: hdl/crs_regset.sv
// CPU programmer register set with banked registers, flags and an AXI4-Lite view
`timescale 1ns/1ns
// Overview of operation
// - Four 16-bit general data registers
// - First two words split into byte halves
// - Third/fourth words form upper pair halves
// - Two 16-bit address registers, operands too
// - Second address word is upper pair half
// - 16-bit frame base register
// - 20-bit vector table base register
// - Two stack pointers chosen by stack flag
// - 16-bit static base register
// - 11-bit flag register of processor state
// - Carry flag captures ALU carry/borrow/shift-out
// - Zero flag set on zero result
// - Sign flag set on negative result
// - Bank flag picks register bank
// - Overflow flag set on overflow
module crs_regset (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Core side
  input wire crs_pkg::crs_wr_t core_wr,
  input wire crs_pkg::crs_alu_t core_alu,
  input wire logic pc_load,
  input wire logic [19:0] pc_value,
  input wire logic flg_load,
  input wire logic [10:0] flg_value,
  output crs_pkg::crs_view_t core_view
);

  // Whole module state
  typedef struct packed {
    crs_pkg::crs_bank_t bank0;
    crs_pkg::crs_bank_t bank1;
    logic [15:0] sb;
    logic [15:0] user_stack_ptr;
    logic [15:0] irq_stack_ptr;
    logic [19:0] vtb;
    logic [19:0] pc;
    logic [10:0] cpu_flags;
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic aw_rdy;
    logic w_rdy;
    logic ar_rdy;
    crs_pkg::crs_view_t view;
  } crs_state_t;

  // Reset image: all clear except the ready lines, which stand high so the first request is taken
  localparam crs_state_t ST_RST = '{aw_rdy: 1'b1, w_rdy: 1'b1, ar_rdy: 1'b1, default: '0};

  crs_state_t st_r;
  crs_state_t st_nxt;

  // Byte-lane merge for bus writes
  function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Byte-lane merge into a 16-bit register; the upper lanes fall outside it
  function automatic logic [15:0] strb_merge16(input logic [15:0] old, input logic [31:0] nw,
                                               input logic [3:0] strb);
    logic [31:0] full;
    full = strb_merge({16'h0000, old}, nw, strb);
    return full[15:0];
  endfunction

  // Build the core view from a state snapshot
  function automatic crs_pkg::crs_view_t make_view(input crs_state_t s);
    crs_pkg::crs_view_t v;
    crs_pkg::crs_bank_t b;
    b = s.cpu_flags[crs_pkg::FLG_B] ? s.bank1 : s.bank0;
    v.gp0 = b.gp0;
    v.gp1 = b.gp1;
    v.gp2 = b.gp2;
    v.gp3 = b.gp3;
    v.gp_pair_even = {b.gp2, b.gp0};
    v.gp_pair_odd = {b.gp3, b.gp1};
    v.aw0 = b.aw0;
    v.aw1 = b.aw1;
    v.addr_pair = {b.aw1, b.aw0};
    v.fb = b.fb;
    v.sb = s.sb;
    v.sp = s.cpu_flags[crs_pkg::FLG_U] ? s.user_stack_ptr : s.irq_stack_ptr;
    v.vtb = s.vtb;
    v.pc = s.pc;
    v.flags = s.cpu_flags;
    return v;
  endfunction

  // Next-state logic: core writes, flag updates, then bus writes
  always_comb begin
    crs_pkg::crs_bank_t cb;
    logic bsel;
    logic [31:0] cur;
    logic [31:0] wv;
    logic [31:0] res;
    logic neg;
    st_nxt = st_r;
    bsel = st_r.cpu_flags[crs_pkg::FLG_B];
    cb = bsel ? st_r.bank1 : st_r.bank0;
    cur = 32'h00000000;
    wv = 32'h00000000;
    res = 32'h00000000;
    neg = 1'b0;
    // Core register writes; banked registers go into the active bank, SB, VTB and SP are shared
    case (core_wr.dst)
      crs_pkg::CRS_DST_GP0: cb.gp0 = core_wr.data[15:0];
      crs_pkg::CRS_DST_GP1: cb.gp1 = core_wr.data[15:0];
      crs_pkg::CRS_DST_GP2: cb.gp2 = core_wr.data[15:0];
      crs_pkg::CRS_DST_GP3: cb.gp3 = core_wr.data[15:0];
      crs_pkg::CRS_DST_GP0L: cb.gp0[7:0] = core_wr.data[7:0];
      crs_pkg::CRS_DST_GP0H: cb.gp0[15:8] = core_wr.data[7:0];
      crs_pkg::CRS_DST_GP1L: cb.gp1[7:0] = core_wr.data[7:0];
      crs_pkg::CRS_DST_GP1H: cb.gp1[15:8] = core_wr.data[7:0];
      crs_pkg::CRS_DST_AW0: cb.aw0 = core_wr.data[15:0];
      crs_pkg::CRS_DST_AW1: cb.aw1 = core_wr.data[15:0];
      crs_pkg::CRS_DST_FB: cb.fb = core_wr.data[15:0];
      crs_pkg::CRS_DST_SB: st_nxt.sb = core_wr.data[15:0];
      crs_pkg::CRS_DST_VTB: st_nxt.vtb = core_wr.data[19:0];
      crs_pkg::CRS_DST_SP: begin
        // Only the active stack pointer is written
        if (st_r.cpu_flags[crs_pkg::FLG_U]) begin
          st_nxt.user_stack_ptr = core_wr.data[15:0];
        end else begin
          st_nxt.irq_stack_ptr = core_wr.data[15:0];
        end
      end
      crs_pkg::CRS_DST_PAIR: begin
        case (core_wr.pair)
          crs_pkg::CRS_PAIR_EVEN: {cb.gp2, cb.gp0} = core_wr.data;
          crs_pkg::CRS_PAIR_ODD: {cb.gp3, cb.gp1} = core_wr.data;
          crs_pkg::CRS_PAIR_ADDR: {cb.aw1, cb.aw0} = core_wr.data;
          default: cb = cb;
        endcase
      end
      default: cb = cb;
    endcase
    if (bsel) begin
      st_nxt.bank1 = cb;
    end else begin
      st_nxt.bank0 = cb;
    end
    // Program counter follows the sequencer
    if (pc_load) begin
      st_nxt.pc = pc_value;
    end
    // Whole-flag load first, ALU updates override the condition bits
    if (flg_load) begin
      st_nxt.cpu_flags = flg_value;
    end
    res = core_alu.wide ? core_alu.result : {16'h0000, core_alu.result[15:0]};
    neg = core_alu.wide ? core_alu.result[31] : core_alu.result[15];
    if (core_alu.upd_c) begin
      st_nxt.cpu_flags[crs_pkg::FLG_C] = core_alu.carry;
    end
    if (core_alu.upd_zs) begin
      st_nxt.cpu_flags[crs_pkg::FLG_Z] = (res == 32'h00000000);
      st_nxt.cpu_flags[crs_pkg::FLG_S] = neg;
    end
    if (core_alu.upd_o) begin
      st_nxt.cpu_flags[crs_pkg::FLG_O] = core_alu.overflow;
    end
    // AXI write channel capture, either order
    if (s_axi_awvalid && !st_r.aw_have && !st_r.bvalid) begin
      st_nxt.aw_have = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_r.w_have && !st_r.bvalid) begin
      st_nxt.w_have = 1'b1;
      st_nxt.w_data = s_axi_wdata;
      st_nxt.w_strb = s_axi_wstrb;
    end
    // Bus write commits once both halves are held; core writes lose to it
    if (st_r.aw_have && st_r.w_have) begin
      st_nxt.aw_have = 1'b0;
      st_nxt.w_have = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = crs_pkg::RESP_OKAY;
      cb = bsel ? st_nxt.bank1 : st_nxt.bank0;
      wv = st_r.w_data;
      case (st_r.aw_addr)
        crs_pkg::OFF_GP0: cb.gp0 = strb_merge16(cb.gp0, wv, st_r.w_strb);
        crs_pkg::OFF_GP1: cb.gp1 = strb_merge16(cb.gp1, wv, st_r.w_strb);
        crs_pkg::OFF_GP2: cb.gp2 = strb_merge16(cb.gp2, wv, st_r.w_strb);
        crs_pkg::OFF_GP3: cb.gp3 = strb_merge16(cb.gp3, wv, st_r.w_strb);
        crs_pkg::OFF_AW0: cb.aw0 = strb_merge16(cb.aw0, wv, st_r.w_strb);
        crs_pkg::OFF_AW1: cb.aw1 = strb_merge16(cb.aw1, wv, st_r.w_strb);
        crs_pkg::OFF_FB: cb.fb = strb_merge16(cb.fb, wv, st_r.w_strb);
        crs_pkg::OFF_VTB: begin
          cur = strb_merge({12'h000, st_nxt.vtb}, wv, st_r.w_strb);
          st_nxt.vtb = cur[19:0];
        end
        crs_pkg::OFF_USP: st_nxt.user_stack_ptr = strb_merge16(st_nxt.user_stack_ptr, wv, st_r.w_strb);
        crs_pkg::OFF_ISP: st_nxt.irq_stack_ptr = strb_merge16(st_nxt.irq_stack_ptr, wv, st_r.w_strb);
        crs_pkg::OFF_SB: st_nxt.sb = strb_merge16(st_nxt.sb, wv, st_r.w_strb);
        crs_pkg::OFF_FLG: begin
          // Debug bit and unused bits are held at zero
          cur = strb_merge({21'h000000, st_nxt.cpu_flags}, wv, st_r.w_strb);
          st_nxt.cpu_flags = cur[10:0] & crs_pkg::FLG_WMASK;
        end
        crs_pkg::OFF_PC: st_nxt.bresp = crs_pkg::RESP_SLVERR; // Read-only
        crs_pkg::OFF_ASP: st_nxt.bresp = crs_pkg::RESP_SLVERR;
        default: st_nxt.bresp = crs_pkg::RESP_SLVERR;
      endcase
      if (bsel) begin
        st_nxt.bank1 = cb;
      end else begin
        st_nxt.bank0 = cb;
      end
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    // AXI read: one beat, answered the cycle after the address is taken
    if (s_axi_arvalid && !st_r.rvalid) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = crs_pkg::RESP_OKAY;
      case (s_axi_araddr)
        crs_pkg::OFF_GP0: st_nxt.rdata = {16'h0000, st_r.view.gp0};
        crs_pkg::OFF_GP1: st_nxt.rdata = {16'h0000, st_r.view.gp1};
        crs_pkg::OFF_GP2: st_nxt.rdata = {16'h0000, st_r.view.gp2};
        crs_pkg::OFF_GP3: st_nxt.rdata = {16'h0000, st_r.view.gp3};
        crs_pkg::OFF_AW0: st_nxt.rdata = {16'h0000, st_r.view.aw0};
        crs_pkg::OFF_AW1: st_nxt.rdata = {16'h0000, st_r.view.aw1};
        crs_pkg::OFF_FB: st_nxt.rdata = {16'h0000, st_r.view.fb};
        crs_pkg::OFF_VTB: st_nxt.rdata = {12'h000, st_r.vtb};
        crs_pkg::OFF_PC: st_nxt.rdata = {12'h000, st_r.pc};
        crs_pkg::OFF_USP: st_nxt.rdata = {16'h0000, st_r.user_stack_ptr};
        crs_pkg::OFF_ISP: st_nxt.rdata = {16'h0000, st_r.irq_stack_ptr};
        crs_pkg::OFF_SB: st_nxt.rdata = {16'h0000, st_r.sb};
        crs_pkg::OFF_FLG: st_nxt.rdata = {21'h000000, st_r.cpu_flags};
        crs_pkg::OFF_ASP: st_nxt.rdata = {16'h0000, st_r.view.sp};
        default: begin
          st_nxt.rdata = 32'h00000000;
          st_nxt.rresp = crs_pkg::RESP_SLVERR;
        end
      endcase
    end else if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    // Ready lines are registered so that every bus output leaves a flip-flop
    st_nxt.aw_rdy = !st_nxt.aw_have && !st_nxt.bvalid;
    st_nxt.w_rdy = !st_nxt.w_have && !st_nxt.bvalid;
    st_nxt.ar_rdy = !st_nxt.rvalid;
    // Registered view tracks the committed state
    st_nxt.view = make_view(st_nxt);
  end

  // State register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= ST_RST; // Registers and flags clear, ready lines high
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign s_axi_awready = st_r.aw_rdy;
  assign s_axi_wready = st_r.w_rdy;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = st_r.ar_rdy;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign core_view = st_r.view;

endmodule // crs_regset

// file: hdl/crs_pkg.sv
// Package for the CPU register set: register map, flag layout and bus types
package crs_pkg;
  // Register word addresses (byte offsets, one aligned word each)
  localparam logic [7:0] OFF_GP0 = 8'h00;
  localparam logic [7:0] OFF_GP1 = 8'h04;
  localparam logic [7:0] OFF_GP2 = 8'h08;
  localparam logic [7:0] OFF_GP3 = 8'h0c;
  localparam logic [7:0] OFF_AW0 = 8'h10;
  localparam logic [7:0] OFF_AW1 = 8'h14;
  localparam logic [7:0] OFF_FB = 8'h18;
  localparam logic [7:0] OFF_VTB = 8'h1c;
  localparam logic [7:0] OFF_PC = 8'h20;
  localparam logic [7:0] OFF_USP = 8'h24;
  localparam logic [7:0] OFF_ISP = 8'h28;
  localparam logic [7:0] OFF_SB = 8'h2c;
  localparam logic [7:0] OFF_FLG = 8'h30;
  localparam logic [7:0] OFF_ASP = 8'h34;
  // Flag bit positions
  localparam int FLG_C = 0;
  localparam int FLG_D = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_S = 3;
  localparam int FLG_B = 4;
  localparam int FLG_O = 5;
  localparam int FLG_U = 7;
  localparam logic [10:0] FLG_WMASK = 11'h0bd; // Debug bit and reserved bits never take a bus write
  // Reset values
  localparam logic [15:0] RST_W16 = 16'h0000;
  localparam logic [19:0] RST_W20 = 20'h00000;
  localparam logic [10:0] RST_FLG = 11'h000;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Core write port selectors
  typedef enum logic [3:0] {
    CRS_DST_NONE = 4'h0, CRS_DST_GP0 = 4'h1, CRS_DST_GP1 = 4'h2, CRS_DST_GP2 = 4'h3,
    CRS_DST_GP3 = 4'h4, CRS_DST_AW0 = 4'h5, CRS_DST_AW1 = 4'h6, CRS_DST_FB = 4'h7,
    CRS_DST_SB = 4'h8, CRS_DST_SP = 4'h9, CRS_DST_VTB = 4'ha,
    CRS_DST_GP0L = 4'hb, CRS_DST_GP0H = 4'hc, CRS_DST_GP1L = 4'hd, CRS_DST_GP1H = 4'he,
    CRS_DST_PAIR = 4'hf
  } crs_dst_t;
  // Pair selector for 32-bit writes
  typedef enum logic [1:0] {
    CRS_PAIR_EVEN = 2'h0, CRS_PAIR_ODD = 2'h1, CRS_PAIR_ADDR = 2'h2
  } crs_pair_t;
  // One bank of switched registers
  typedef struct packed {
    logic [15:0] gp0;
    logic [15:0] gp1;
    logic [15:0] gp2;
    logic [15:0] gp3;
    logic [15:0] aw0;
    logic [15:0] aw1;
    logic [15:0] fb;
  } crs_bank_t;
  // Core write request
  typedef struct packed {
    crs_dst_t dst;
    crs_pair_t pair;
    logic [31:0] data;
  } crs_wr_t;
  // ALU flag update request
  typedef struct packed {
    logic upd_c;
    logic upd_zs;
    logic upd_o;
    logic carry;
    logic overflow;
    logic [31:0] result;
    logic wide;
  } crs_alu_t;
  // Register view presented to the core
  typedef struct packed {
    logic [15:0] gp0;
    logic [15:0] gp1;
    logic [15:0] gp2;
    logic [15:0] gp3;
    logic [31:0] gp_pair_even;
    logic [31:0] gp_pair_odd;
    logic [15:0] aw0;
    logic [15:0] aw1;
    logic [31:0] addr_pair;
    logic [15:0] fb;
    logic [15:0] sb;
    logic [15:0] sp;
    logic [19:0] vtb;
    logic [19:0] pc;
    logic [10:0] flags;
  } crs_view_t;
endpackage

// file: bench/crs_regset_checker.sv
// Port-level assertions for the CPU register set
`timescale 1ns/1ns
module crs_regset_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Bus handshakes
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // Core side
  input wire crs_pkg::crs_wr_t core_wr,
  input wire crs_pkg::crs_alu_t core_alu,
  input wire logic pc_load,
  input wire logic [19:0] pc_value,
  input wire logic flg_load,
  input wire crs_pkg::crs_view_t core_view
);
  logic quiet;
  // No bus commit or flag load can collide with the core update this cycle
  assign quiet = s_axi_awready && s_axi_wready && !flg_load;
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  property p_rd_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_gp0;
    core_wr.dst == crs_pkg::CRS_DST_GP0 && quiet |=> core_view.gp0 == $past(core_wr.data[15:0]);
  endproperty
  a_gp0: assert property (p_gp0) else $error("word write lost");
  property p_byte;
    core_wr.dst == crs_pkg::CRS_DST_GP0L && quiet
      |=> core_view.gp0 == {$past(core_view.gp0[15:8]), $past(core_wr.data[7:0])};
  endproperty
  a_byte: assert property (p_byte) else $error("byte write wrong");
  property p_pair;
    core_wr.dst == crs_pkg::CRS_DST_PAIR && core_wr.pair == crs_pkg::CRS_PAIR_ODD && quiet
      |=> core_view.gp_pair_odd == $past(core_wr.data);
  endproperty
  a_pair: assert property (p_pair) else $error("pair write wrong");
  property p_apair;
    core_wr.dst == crs_pkg::CRS_DST_PAIR && core_wr.pair == crs_pkg::CRS_PAIR_ADDR && quiet
      |=> core_view.aw1 == $past(core_wr.data[31:16]) && core_view.addr_pair == $past(core_wr.data);
  endproperty
  a_apair: assert property (p_apair) else $error("address pair order");
  property p_pc;
    pc_load |=> core_view.pc == $past(pc_value);
  endproperty
  a_pc: assert property (p_pc) else $error("counter load lost");
  property p_carry;
    core_alu.upd_c && quiet |=> core_view.flags[crs_pkg::FLG_C] == $past(core_alu.carry);
  endproperty
  a_carry: assert property (p_carry) else $error("carry flag wrong");
  property p_zero;
    core_alu.upd_zs && !core_alu.wide && quiet
      |=> core_view.flags[crs_pkg::FLG_Z] == $past(core_alu.result[15:0] == 16'h0000);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  property p_sign;
    core_alu.upd_zs && quiet |=> core_view.flags[crs_pkg::FLG_S]
      == $past(core_alu.wide ? core_alu.result[31] : core_alu.result[15]);
  endproperty
  a_sign: assert property (p_sign) else $error("sign flag wrong");
  property p_ovf;
    core_alu.upd_o && quiet |=> core_view.flags[crs_pkg::FLG_O] == $past(core_alu.overflow);
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag wrong");
endmodule // crs_regset_checker
bind crs_regset crs_regset_checker chk_i (.mclk, .arst_n, .s_axi_awready, .s_axi_wready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .core_wr, .core_alu, .pc_load, .pc_value,
  .flg_load, .core_view);

// file: bench/crs_cpu_model.sv
// Behavioural model of the decoder and ALU driving the register set
`timescale 1ns/1ns
module crs_cpu_model (
  // Clock
  input wire logic mclk,
  // Core side drive
  output crs_pkg::crs_wr_t core_wr,
  output crs_pkg::crs_alu_t core_alu,
  output logic pc_load,
  output logic [19:0] pc_value,
  output logic flg_load,
  output logic [10:0] flg_value
);
  // Idle at time zero; each operation lasts one clock, then idles a clock
  initial begin
    core_wr = '0;
    core_alu = '0;
    {pc_load, pc_value, flg_load, flg_value} = '0;
  end
  // Register write from the decoder
  task automatic wr(input crs_pkg::crs_dst_t d, input crs_pkg::crs_pair_t p, input logic [31:0] v);
    @(posedge mclk);
    core_wr <= '{d, p, v};
    @(posedge mclk);
    core_wr <= '0;
  endtask
  // ALU result with every flag strobe raised
  task automatic alu(input logic c, input logic o, input logic [31:0] r, input logic w);
    @(posedge mclk);
    core_alu <= '{1'b1, 1'b1, 1'b1, c, o, r, w};
    @(posedge mclk);
    core_alu <= '0;
  endtask
  // Jump with a raw flag load; debug is masked since the core never sets it
  task automatic jmp(input logic [19:0] a, input logic [10:0] f);
    @(posedge mclk);
    {pc_load, pc_value, flg_load} <= {1'b1, a, 1'b1};
    flg_value <= f & ~(11'h001 << crs_pkg::FLG_D);
    @(posedge mclk);
    {pc_load, flg_load} <= 2'b00;
  endtask
endmodule // crs_cpu_model

// file: bench/testbench.sv
// Self-checking bench for the CPU register set
`timescale 1ns/1ns
module testbench;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  crs_pkg::crs_wr_t core_wr;
  crs_pkg::crs_alu_t core_alu;
  crs_pkg::crs_view_t core_view;
  logic pc_load, flg_load;
  logic [19:0] pc_value;
  logic [10:0] flg_value;
  int err_total = 0;
  int compares = 0;
  localparam logic [1:0] OK = crs_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = crs_pkg::RESP_SLVERR;
  // 100 MHz clock
  always #5 mclk = ~mclk;
  crs_cpu_model cpu_m (.mclk, .core_wr, .core_alu, .pc_load, .pc_value, .flg_load, .flg_value);
  crs_regset crs_regset_i (.mclk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .core_wr, .core_alu, .pc_load, .pc_value, .flg_load,
    .flg_value, .core_view);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // Write with both halves offered together; ready lines are sampled at the edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic aw, w;
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
    {s_axi_awvalid, s_axi_wvalid} <= 2'b11;
    {aw, w} = 2'b00;
    while (!(aw && w)) begin
      @(posedge mclk);
      if (!aw && s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  // Read and compare data and response
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge mclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  // Flag reset value, widths and refused places
  task automatic t_map();
    logic [7:0] a [4] = '{crs_pkg::OFF_VTB, crs_pkg::OFF_FB, crs_pkg::OFF_SB, crs_pkg::OFF_AW0};
    logic [31:0] e [4] = '{32'h000fffff, 32'h0000ffff, 32'h0000ffff, 32'h0000ffff};
    rd(crs_pkg::OFF_FLG, 32'h0, OK);
    for (int i = 0; i < 4; i++) begin
      wr(a[i], 32'hffffffff, 4'hf, OK);
      rd(a[i], e[i], OK);
    end
    wr(crs_pkg::OFF_FLG, 32'h7ff, 4'hf, OK);
    rd(crs_pkg::OFF_FLG, 32'h0bd, OK);
    wr(crs_pkg::OFF_FLG, 32'h0, 4'hf, OK);
    rd(8'h38, 32'h0, ERR);
    wr(8'h3c, 32'h1, 4'hf, ERR);
    wr(crs_pkg::OFF_GP3, 32'h0000ffff, 4'hf, OK);
    wr(crs_pkg::OFF_GP3, 32'h00005566, 4'h1, OK);
    rd(crs_pkg::OFF_GP3, 32'h0000ff66, OK);
    $display("test map done");
  endtask
  // Banks, stacks and core writes
  task automatic t_bank();
    wr(crs_pkg::OFF_GP0, 32'haaaa, 4'hf, OK);
    wr(crs_pkg::OFF_FLG, 32'h10, 4'hf, OK);
    wr(crs_pkg::OFF_GP0, 32'hbbbb, 4'hf, OK);
    rd(crs_pkg::OFF_GP0, 32'hbbbb, OK);
    wr(crs_pkg::OFF_FLG, 32'h00, 4'hf, OK);
    rd(crs_pkg::OFF_GP0, 32'haaaa, OK);
    wr(crs_pkg::OFF_ISP, 32'h1111, 4'hf, OK);
    wr(crs_pkg::OFF_USP, 32'h2222, 4'hf, OK);
    rd(crs_pkg::OFF_ASP, 32'h1111, OK);
    wr(crs_pkg::OFF_FLG, 32'h80, 4'hf, OK);
    rd(crs_pkg::OFF_ASP, 32'h2222, OK);
    wr(crs_pkg::OFF_GP1, 32'h1122, 4'hf, OK);
    cpu_m.wr(crs_pkg::CRS_DST_GP1H, crs_pkg::CRS_PAIR_EVEN, 32'h000000ab);
    rd(crs_pkg::OFF_GP1, 32'hab22, OK);
    cpu_m.wr(crs_pkg::CRS_DST_GP0L, crs_pkg::CRS_PAIR_EVEN, 32'h00000077);
    cpu_m.wr(crs_pkg::CRS_DST_PAIR, crs_pkg::CRS_PAIR_ODD, 32'h12345678);
    rd(crs_pkg::OFF_GP3, 32'h1234, OK);
    cpu_m.wr(crs_pkg::CRS_DST_PAIR, crs_pkg::CRS_PAIR_ADDR, 32'hdeadbeef);
    rd(crs_pkg::OFF_AW1, 32'hdead, OK);
    $display("test bank done");
  endtask
  // Each core write destination but GP1, GP0L, GP1H and the odd and address pairs lands where the bus reads it; FB and SP also in bank 1
  task automatic t_core();
    crs_pkg::crs_dst_t d [8] = '{crs_pkg::CRS_DST_GP2, crs_pkg::CRS_DST_GP3, crs_pkg::CRS_DST_AW0,
      crs_pkg::CRS_DST_AW1, crs_pkg::CRS_DST_FB, crs_pkg::CRS_DST_SB, crs_pkg::CRS_DST_VTB,
      crs_pkg::CRS_DST_SP};
    logic [7:0] a [8] = '{crs_pkg::OFF_GP2, crs_pkg::OFF_GP3, crs_pkg::OFF_AW0, crs_pkg::OFF_AW1,
      crs_pkg::OFF_FB, crs_pkg::OFF_SB, crs_pkg::OFF_VTB, crs_pkg::OFF_USP};
    for (int i = 0; i < 8; i++) begin
      cpu_m.wr(d[i], crs_pkg::CRS_PAIR_EVEN, 32'hfffc1000 + i);
      rd(a[i], i == 6 ? 32'h000c1006 : 32'h1000 + i, OK);
    end
    cpu_m.wr(crs_pkg::CRS_DST_GP0, crs_pkg::CRS_PAIR_EVEN, 32'h00004321);
    rd(crs_pkg::OFF_GP0, 32'h4321, OK);
    cpu_m.wr(crs_pkg::CRS_DST_GP0H, crs_pkg::CRS_PAIR_EVEN, 32'h000000a5);
    cpu_m.wr(crs_pkg::CRS_DST_GP1L, crs_pkg::CRS_PAIR_EVEN, 32'h0000005a);
    rd(crs_pkg::OFF_GP0, 32'ha521, OK);
    rd(crs_pkg::OFF_GP1, 32'h565a, OK);
    cpu_m.wr(crs_pkg::CRS_DST_PAIR, crs_pkg::CRS_PAIR_EVEN, 32'h9abcdef0);
    rd(crs_pkg::OFF_GP2, 32'h9abc, OK);
    chk(core_view.gp_pair_even, 32'h9abcdef0);
    wr(crs_pkg::OFF_FLG, 32'h10, 4'hf, OK);
    cpu_m.wr(crs_pkg::CRS_DST_SP, crs_pkg::CRS_PAIR_EVEN, 32'h00001357);
    cpu_m.wr(crs_pkg::CRS_DST_FB, crs_pkg::CRS_PAIR_EVEN, 32'h00002468);
    rd(crs_pkg::OFF_ISP, 32'h1357, OK);
    rd(crs_pkg::OFF_FB, 32'h2468, OK);
    chk({16'h0000, core_view.sp}, 32'h00001357);
    wr(crs_pkg::OFF_FLG, 32'h80, 4'hf, OK);
    rd(crs_pkg::OFF_FB, 32'h1004, OK);
    $display("test core done");
  endtask
  // ALU flags, counter load and its write refusal
  task automatic t_cpu();
    cpu_m.alu(1'b1, 1'b1, 32'h00008000, 1'b0);
    rd(crs_pkg::OFF_FLG, 32'h0a9, OK);
    cpu_m.alu(1'b0, 1'b0, 32'h00010000, 1'b0);
    rd(crs_pkg::OFF_FLG, 32'h084, OK);
    cpu_m.alu(1'b0, 1'b0, 32'h00010000, 1'b1);
    rd(crs_pkg::OFF_FLG, 32'h080, OK);
    cpu_m.jmp(20'habcde, 11'h002);
    rd(crs_pkg::OFF_PC, 32'h000abcde, OK);
    chk({12'h000, core_view.pc}, 32'h000abcde);
    wr(crs_pkg::OFF_PC, 32'h1, 4'hf, ERR);
    rd(crs_pkg::OFF_FLG, 32'h0, OK);
    $display("test cpu done");
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Watchdog far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    err_total++;
    give_verdict();
  end
  initial begin
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    t_map();
    t_bank();
    t_core();
    t_cpu();
    give_verdict();
  end
endmodule // testbench
